// ### hdl/ttri_map.vh
// Constants for the tape transport reset interlock block
`ifndef TTRI_MAP_VH
`define TTRI_MAP_VH
// System clock rate in kHz
`define TTRI_CLK_KHZ 40000
// Base tap rate in kHz
`define TTRI_BASE_KHZ 1000
// Cycles of clk per 1 MHz base tick
`define TTRI_BASE_DIV (`TTRI_CLK_KHZ / `TTRI_BASE_KHZ)
// Each decade stage divides by ten
`define TTRI_DECADE 10
// Number of decade stages after the base: 100k,10k,1k,100,10 Hz
`define TTRI_STAGES 5
// Last count of the base divider (40 - 1) and of a decade stage (10 - 1)
`define TTRI_BASE_LAST 6'h27
`define TTRI_DECADE_LAST 4'h9
// Reset hold after button release, in microseconds
`define TTRI_HOLD_US 10
// Hold expressed in 100 kHz ticks (10 us per tick)
`define TTRI_HOLD_TICKS (`TTRI_HOLD_US / 10)
// Reset values
`define TTRI_RST_LOW 1'b0
`define TTRI_RST_HIGH 1'b1
`endif

// ### hdl/ttri_sync.v
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`include "ttri_map.vh"
module ttri_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
)
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule

// ### hdl/ttri_top.v
// Reset, timing and interlock logic of the tape transport control board
// How it works
// [R1] Decade taps from 1 MHz: 1 MHz, 100 kHz, 10 kHz used; 1 kHz and 100 Hz unused.
// [R2] A 10 Hz tap is produced for load fault and motion timing.
// [R3] Read/write, density and load/rewind/unload/test modes may coexist.
// [R4] Returning power clears and resets circuits through the power-on pulse.
// [R5] A brief reset pushbutton press also enters the reset state.
// [R6] Power-on pulse enables the front panel indicators.
// [R7] Master reset asserts on power-on pulse or synchronized pushbutton.
// [R8] Pushbutton latched in set/clear flop; closed NC clears, NO sets.
// [R9] Latch passes two 100 kHz stages; both outputs start master reset.
// [R10] Button-made reset holds about 10 us after release.
// [R11] Master reset presets rewind status and clears on-line status.
// [R12] Master reset enables the blower motor signal.
// [R13] Master reset clears load fault, re-enabling motion command outputs.
// [R14] Load-procedure reset comes from master reset or interlock.
// [R15] Counter reset is master reset ORed with other sources.
// [R16] Interlock low only when all four air and tape conditions hold.
// [R17] A switch closed to ground, a low input, means satisfied.
// [R18] Nine-track flag is strapped permanently high.
// [R19] Density select low means PE, high means NRZI.
// [R20] Host low density request or PE strap forces PE mode.
// [R21] Density indicator driven while unit selection is asserted.
// [R22] Start-marker interlock is high while marker sensor input is low.
// [R23] Switch and sensor inputs pass two flops before use.
`timescale 1ns/1ps
`include "ttri_map.vh"
module ttri_top
(
  // Clock and reset
  clk,
  rst,
  // Power and operator panel
  power_on_pulse_n,
  reset_button_nc,
  reset_button_no,
  // Air and tape sensors
  supply_loop_limit_n,
  takeup_loop_limit_n,
  vacuum_ok_n,
  air_pressure_ok_n,
  start_marker_sensed_n,
  // Formatter and straps
  host_density_request_n,
  pe_strap_n,
  // Events from other sequencers
  rewind_done,
  online_set,
  load_fault_set,
  blower_stop,
  counter_reset_extra,
  // Mode requests from other sequencers
  mode_req,
  // Timing taps
  tick_1mhz,
  tick_100khz,
  tick_10khz,
  tick_10hz,
  // Resets out
  master_reset_pulse_n,
  rewind_online_reset_n,
  load_procedure_reset_n,
  counter_reset,
  // Status out
  indicators_enable,
  rewind_status,
  online_status,
  load_fault_flag,
  load_fault_status_n,
  motion_enable,
  blower_run,
  air_tape_ok_n,
  nine_track_flag,
  high_density_select_n,
  density_indicator_out,
  density_indicator_oe,
  unit_chosen,
  unit_chosen_n,
  start_marker_interlock,
  mode_active
);
  input wire clk;
  input wire rst;
  input wire power_on_pulse_n;
  input wire reset_button_nc;
  input wire reset_button_no;
  input wire supply_loop_limit_n;
  input wire takeup_loop_limit_n;
  input wire vacuum_ok_n;
  input wire air_pressure_ok_n;
  input wire start_marker_sensed_n;
  input wire host_density_request_n;
  input wire pe_strap_n;
  input wire rewind_done;
  input wire online_set;
  input wire load_fault_set;
  input wire blower_stop;
  input wire counter_reset_extra;
  input wire [7:0] mode_req;
  output wire tick_1mhz;
  output wire tick_100khz;
  output wire tick_10khz;
  output wire tick_10hz;
  output reg master_reset_pulse_n;
  output wire rewind_online_reset_n;
  output reg load_procedure_reset_n;
  output reg counter_reset;
  output reg indicators_enable;
  output wire rewind_status;
  output wire online_status;
  output wire load_fault_flag;
  output wire load_fault_status_n;
  output wire motion_enable;
  output wire blower_run;
  output reg air_tape_ok_n;
  output wire nine_track_flag;
  output reg high_density_select_n;
  output reg density_indicator_out;
  output wire density_indicator_oe;
  output wire unit_chosen;
  output wire unit_chosen_n;
  output reg start_marker_interlock;
  output reg [7:0] mode_active;

  // Synchronised asynchronous inputs, order fixed by the concatenation
  localparam NSYNC = 10;
  wire [NSYNC-1:0] raw_in;
  wire [NSYNC-1:0] sync_in;
  assign raw_in = {power_on_pulse_n, reset_button_nc, reset_button_no,
                   supply_loop_limit_n, takeup_loop_limit_n, vacuum_ok_n,
                   air_pressure_ok_n, start_marker_sensed_n,
                   host_density_request_n, pe_strap_n};

  ttri_sync #(.W(NSYNC), .INIT({NSYNC{1'b1}})) u_sync
  (
    .clk(clk),
    .rst(rst),
    .d(raw_in),
    .q(sync_in)
  ); // R23

  wire por_n;
  wire btn_nc;
  wire btn_no;
  wire [3:0] sense_n;
  wire marker_n;
  wire dens_req_n;
  wire strap_n;
  assign por_n = sync_in[9];
  assign btn_nc = sync_in[8];
  assign btn_no = sync_in[7];
  assign sense_n = sync_in[6:3];
  assign marker_n = sync_in[2];
  assign dens_req_n = sync_in[1];
  assign strap_n = sync_in[0];

  // Base divider to 1 MHz
  reg [5:0] base_cnt_q;
  reg base_tick_q;
  always @(posedge clk)
  begin
    if (rst)
    begin
      base_cnt_q <= 6'h00;
      base_tick_q <= `TTRI_RST_LOW;
    end
    else if (base_cnt_q == `TTRI_BASE_LAST)
    begin
      base_cnt_q <= 6'h00;
      base_tick_q <= `TTRI_RST_HIGH;
    end
    else
    begin
      base_cnt_q <= base_cnt_q + 6'h01;
      base_tick_q <= `TTRI_RST_LOW;
    end
  end

  // Decade chain; each stage pulses once per ten pulses of the one above
  wire [`TTRI_STAGES:0] tap;
  assign tap[0] = base_tick_q;
  genvar g;
  generate
    for (g = 0; g < `TTRI_STAGES; g = g + 1)
    begin : dec
      reg [3:0] cnt_q;
      always @(posedge clk)
      begin
        if (rst)
          cnt_q <= 4'h0;
        else if (tap[g])
          cnt_q <= (cnt_q == `TTRI_DECADE_LAST) ? 4'h0 : cnt_q + 4'h1;
      end
      assign tap[g+1] = tap[g] && (cnt_q == `TTRI_DECADE_LAST);
    end
  endgenerate

  assign tick_1mhz = tap[0]; // R1
  assign tick_100khz = tap[1]; // R1
  assign tick_10khz = tap[2]; // R1
  // Tap 3 (1 kHz) and tap 4 (100 Hz) only feed the next stage
  assign tick_10hz = tap[5]; // R2

  // Pushbutton latch: NC contact closed (low) holds it cleared
  reg btn_latch_q;
  always @(posedge clk)
  begin
    if (rst)
      btn_latch_q <= `TTRI_RST_LOW;
    else if (!btn_nc)
      btn_latch_q <= `TTRI_RST_LOW; // R8
    else if (!btn_no)
      btn_latch_q <= `TTRI_RST_HIGH; // R8
  end

  // Two stages on the 100 kHz tap; the second gives the release hold
  reg stage1_q;
  reg stage2_q;
  always @(posedge clk)
  begin
    if (rst)
    begin
      stage1_q <= `TTRI_RST_LOW;
      stage2_q <= `TTRI_RST_LOW;
    end
    else if (tick_100khz)
    begin
      stage1_q <= btn_latch_q; // R9
      stage2_q <= stage1_q; // R9
    end
  end

  // Either stage keeps the pulse, so it outlasts release by one to two 10 us ticks
  wire button_req;
  assign button_req = stage1_q | stage2_q; // R9 R10 R5

  // Master reset and its distribution; registered for clean outputs
  wire mr;
  assign mr = !por_n || button_req; // R7 R4
  always @(posedge clk)
  begin
    if (rst)
    begin
      master_reset_pulse_n <= `TTRI_RST_LOW;
      load_procedure_reset_n <= `TTRI_RST_LOW;
      counter_reset <= `TTRI_RST_HIGH;
      indicators_enable <= `TTRI_RST_LOW;
      air_tape_ok_n <= `TTRI_RST_HIGH;
      start_marker_interlock <= `TTRI_RST_LOW;
      high_density_select_n <= `TTRI_RST_HIGH;
      density_indicator_out <= `TTRI_RST_LOW;
      mode_active <= 8'h00;
    end
    else
    begin
      master_reset_pulse_n <= !mr; // R7
      indicators_enable <= !por_n; // R6
      air_tape_ok_n <= !(sense_n == 4'h0); // R16 R17
      load_procedure_reset_n <= !(mr || (sense_n != 4'h0)); // R14
      counter_reset <= mr || counter_reset_extra; // R15
      start_marker_interlock <= !marker_n; // R22
      high_density_select_n <= !(!dens_req_n || !strap_n); // R19 R20
      density_indicator_out <= !strap_n; // R21
      // Modes are independent bits, cleared by master reset
      mode_active <= mr ? 8'h00 : mode_req; // R3
    end
  end

  // Status flops; a later event does not override reset while it is held
  reg rewind_q;
  reg online_q;
  reg fault_q;
  reg blower_q;
  always @(posedge clk)
  begin
    if (rst)
    begin
      rewind_q <= `TTRI_RST_HIGH;
      online_q <= `TTRI_RST_LOW;
      fault_q <= `TTRI_RST_LOW;
      blower_q <= `TTRI_RST_HIGH;
    end
    else if (mr)
    begin
      rewind_q <= `TTRI_RST_HIGH; // R11
      online_q <= `TTRI_RST_LOW; // R11
      fault_q <= `TTRI_RST_LOW; // R13
      blower_q <= `TTRI_RST_HIGH; // R12
    end
    else
    begin
      if (rewind_done)
        rewind_q <= `TTRI_RST_LOW;
      if (online_set)
        online_q <= `TTRI_RST_HIGH;
      if (load_fault_set)
        fault_q <= `TTRI_RST_HIGH;
      if (blower_stop)
        blower_q <= `TTRI_RST_LOW;
    end
  end

  assign rewind_online_reset_n = master_reset_pulse_n; // R11
  assign rewind_status = rewind_q;
  assign online_status = online_q;
  assign load_fault_flag = fault_q;
  assign load_fault_status_n = !fault_q;
  assign motion_enable = !fault_q; // R13
  assign blower_run = blower_q; // R12
  assign nine_track_flag = 1'b1; // R18
  assign unit_chosen = 1'b1;
  assign unit_chosen_n = 1'b0;
  assign density_indicator_oe = unit_chosen; // R21
endmodule

// ### tb/ttri_chk.sv
// Port checker for the reset interlock block
`timescale 1ns/1ps
module ttri_chk (
  // Clock and reset
  input wire clk, rst,
  // Pins
  input wire power_on_pulse_n, supply_loop_limit_n, takeup_loop_limit_n,
  input wire vacuum_ok_n, air_pressure_ok_n, host_density_request_n,
  input wire pe_strap_n,
  // Outputs
  input wire tick_1mhz, tick_10khz, tick_10hz, master_reset_pulse_n,
  input wire load_procedure_reset_n,
  input wire counter_reset, indicators_enable, rewind_status, online_status,
  input wire load_fault_flag, motion_enable, blower_run, air_tape_ok_n,
  input wire high_density_select_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [3:0] s = {supply_loop_limit_n, takeup_loop_limit_n, vacuum_ok_n,
    air_pressure_ok_n};
  wire pe = !host_density_request_n || !pe_strap_n;
  wire mr = !master_reset_pulse_n;
  // Two sync flops plus an output reg: a pin level must hold four samples
  property p_ok; (s == 4'h0)[*4] |-> !air_tape_ok_n; endproperty
  a_ok: assert property (p_ok) else $error("no interlock");
  property p_nok;
    (s != 4'h0)[*4] |-> air_tape_ok_n && !load_procedure_reset_n;
  endproperty
  a_nok: assert property (p_nok) else $error("bad interlock");
  property p_pe; pe[*4] |-> !high_density_select_n; endproperty
  a_pe: assert property (p_pe) else $error("no high density");
  property p_nrz; (!pe)[*4] |-> high_density_select_n; endproperty
  a_nrz: assert property (p_nrz) else $error("no low density");
  property p_por; (!power_on_pulse_n)[*4] |-> mr && indicators_enable;
  endproperty
  a_por: assert property (p_por) else $error("no power reset");
  property p_mr;
    mr[*3] |-> rewind_status && !online_status && !load_fault_flag &&
      blower_run && counter_reset;
  endproperty
  a_mr: assert property (p_mr) else $error("bad reset");
  property p_mot; motion_enable == !load_fault_flag; endproperty
  a_mot: assert property (p_mot) else $error("bad motion");
  property p_tap; tick_1mhz |-> ##40 tick_1mhz; endproperty
  a_tap: assert property (p_tap) else $error("bad tap");
  // The slowest tap only fires on a cycle where the 10 kHz tap fires
  property p_slow; tick_10hz |-> tick_10khz; endproperty
  a_slow: assert property (p_slow) else $error("bad slow tap");
  c_ok: cover property ($fell(air_tape_ok_n));
  c_pe: cover property ($fell(high_density_select_n));
  c_mr: cover property ($rose(master_reset_pulse_n));
endmodule

bind ttri_top ttri_chk u_chk (.*);

// ### tb/ttri_panel.sv
// Model of the operator panel, air sensors and formatter density line
`timescale 1ns/1ps
module ttri_panel (
  // Clock
  input wire clk,
  // Bench requests
  input wire press,
  input wire [3:0] sat,
  input wire want_pe,
  // Pins
  output reg reset_button_nc = 1'h0,
  output reg reset_button_no = 1'h1,
  output wire [3:0] sn,
  output wire host_density_request_n
);
  // Break before make: the two contacts are never closed together
  always @(posedge clk)
  begin
    reset_button_nc <= press | ~reset_button_no;
    reset_button_no <= ~(press & reset_button_nc);
  end
  assign sn = ~sat;
  assign host_density_request_n = ~want_pe;
endmodule

// ### tb/ttri_top_tb.sv
// Random and corner tests of the reset interlock block
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %0t %h %h", $time, a, e); end end
module ttri_top_tb;
  reg clk = 1'h0, rst = 1'h1, power_on_pulse_n = 1'h1, press = 1'h0;
  reg want_pe = 1'h0, pe_strap_n = 1'h1, start_marker_sensed_n = 1'h1;
  reg counter_reset_extra = 1'h0;
  reg [3:0] ev = 4'h0;
  reg [3:0] sat = 4'hf;
  reg [7:0] mode_req = 8'h00;
  integer error_cnt = 0, n_tests = 0, i, n;
  wire reset_button_nc, reset_button_no, host_density_request_n;
  wire tick_1mhz, tick_100khz, tick_10khz, master_reset_pulse_n;
  wire load_procedure_reset_n, counter_reset, indicators_enable;
  wire rewind_status, online_status, load_fault_flag, load_fault_status_n;
  wire motion_enable, blower_run, air_tape_ok_n, high_density_select_n;
  wire start_marker_interlock;
  wire tick_10hz, rewind_online_reset_n, nine_track_flag, unit_chosen;
  wire unit_chosen_n, density_indicator_out, density_indicator_oe;
  wire [3:0] sn;
  wire [7:0] mode_active;
  wire [2:0] tk = {tick_10khz, tick_100khz, tick_1mhz};
  wire [2:0] rs = {master_reset_pulse_n, indicators_enable, counter_reset};
  wire [5:0] st = {rewind_status, online_status, load_fault_flag,
    blower_run, motion_enable, load_fault_status_n};
  ttri_panel u_pnl (.*);
  ttri_top DUT (.*, .supply_loop_limit_n(sn[3]),
    .takeup_loop_limit_n(sn[2]), .vacuum_ok_n(sn[1]),
    .air_pressure_ok_n(sn[0]), .rewind_done(ev[3]), .online_set(ev[2]),
    .load_fault_set(ev[1]), .blower_stop(ev[0]));
  always #12.5 clk = ~clk;
  function integer period(input integer k);
    period = 40 * 10 ** k;
  endfunction
  task tally_and_finish;
  begin
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // The button reset may take two slow taps, so allow a generous bound
  task wait_mr(input v);
  begin
    n = 0;
    while (master_reset_pulse_n !== v && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 1000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end
  endtask
  task gap(input integer k);
  begin
    n = 0;
    while (tk[k] !== 1'h1 && n < 9000)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tk[k] !== 1'h1 && n < 9000);
    `CHK(n, period(k))
  end
  endtask
  initial
  begin
    n = $urandom(32'h0000_a089);
    repeat (16) @(negedge clk);
    rst = 1'h0;
    `CHK(st, 6'h27)
    repeat (4) @(negedge clk);
    for (i = 0; i < 40; i++)
    begin
      sat = (i < 5) ? 4'hf ^ (4'h1 << i) : $urandom;
      {want_pe, pe_strap_n, start_marker_sensed_n, mode_req} = $urandom;
      @(negedge clk);
      `CHK(mode_active, mode_req)
      repeat (3) @(negedge clk);
      `CHK({air_tape_ok_n, load_procedure_reset_n}, {~&sat, &sat})
      `CHK(high_density_select_n, ~want_pe & pe_strap_n)
      `CHK(start_marker_interlock, ~start_marker_sensed_n)
      `CHK(density_indicator_out, ~pe_strap_n)
      `CHK({nine_track_flag, unit_chosen, unit_chosen_n}, 3'h6)
      `CHK(density_indicator_oe, 1'h1)
    end
    ev = 4'hf;
    @(negedge clk);
    ev = 4'h0;
    @(negedge clk);
    `CHK(st, 6'h18)
    // Online set is held through the pulse; the reset must win
    power_on_pulse_n = 1'h0;
    ev = 4'h4;
    repeat (6) @(negedge clk);
    `CHK({rs, st}, 9'h0e7)
    `CHK({rewind_online_reset_n, mode_active}, 9'h000)
    power_on_pulse_n = 1'h1;
    ev = 4'h0;
    counter_reset_extra = 1'h1;
    repeat (6) @(negedge clk);
    `CHK(rs, 3'h5)
    `CHK(rewind_online_reset_n, 1'h1)
    counter_reset_extra = 1'h0;
    press = 1'h1;
    wait_mr(1'h0);
    `CHK(n < 810, 1'h1)
    repeat (20) @(negedge clk);
    press = 1'h0;
    wait_mr(1'h1);
    `CHK(n >= 400 && n < 820, 1'h1)
    for (i = 0; i < 3; i++)
      gap(i);
    `CHK(tick_10hz, 1'h0)
    tally_and_finish;
  end
endmodule
